/* lpcm_pkg.sv */
package lpcm_pkg;
    localparam logic [1:0] MODE_BYTE_MASTER_PINS = 2'h0;
    localparam logic [1:0] MODE_PACKET = 2'h1;
    localparam logic [1:0] MODE_BYTE_PREBOOT = 2'h2;
    localparam logic [1:0] MODE_PACKET_PREBOOT = 2'h3;
    localparam int CLK_MHZ = 100;
    localparam int OS_RATE_MBPS = 20;
    localparam int OVERSAMPLE = 5;
    localparam int SAMPLE_DIV = CLK_MHZ * 1 > OS_RATE_MBPS * OVERSAMPLE ?
        CLK_MHZ / (OS_RATE_MBPS * OVERSAMPLE) : 1;
    localparam int BIT_CYCLES = SAMPLE_DIV * OVERSAMPLE;
    localparam int DS_RATE_MBPS = 100;
    localparam int DATA_BITS = 8;
    localparam int FRAME_BITS = DATA_BITS + 3;
    localparam logic [15:0] RESET_OUT_CYCLES = 16'h0010;
    localparam int BUF_DEPTH = 2;

    typedef struct packed {
        logic byte_stream;
        logic master_from_pins;
        logic link0_preboot;
    } lpcm_mode_t;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } lpcm_byte_t;
endpackage

/* lpcm_buf.sv */
`timescale 1ns/100ps
module lpcm_buf #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
) (
    input wire logic i_mclk,
    input wire logic i_reset,
    input wire logic i_valid,
    output logic o_ready,
    input wire logic [WIDTH-1:0] i_data,
    output logic o_valid,
    input wire logic i_ready,
    output logic [WIDTH-1:0] o_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    logic push;
    logic pop;

    assign push = i_valid && o_ready;
    assign pop = o_valid && i_ready;

    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
            // ready stays low while held in reset, so a disabled path refuses bytes
            o_ready <= 1'b0;
            o_valid <= 1'b0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
            o_ready <= (cnt_q + (AW+1)'(push) - (AW+1)'(pop)) != (AW+1)'(DEPTH);
            o_valid <= (cnt_q + (AW+1)'(push) - (AW+1)'(pop)) != '0;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (push) begin
            mem_q[wr_q] <= i_data;
        end
    end

    // read data registered so the head word is stable while stalled
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            o_data <= '0;
        end else if (cnt_q == '0 || pop) begin
            if (pop && cnt_q > 1) begin
                o_data <= mem_q[(rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1];
            end else if (push) begin
                o_data <= i_data;
            end
        end
    end
endmodule

/* lpcm_top.sv */
`timescale 1ns/100ps
// Operation
// - mode pins decode high-pin-upper; even modes byte-stream, odd modes packetized
// - mode 0 mastered by discrete pins, other modes by control link zero
// - modes 2 and 3 run pre-boot protocol on legacy link zero until booted
// - mode 0 target reset with analyse low resets converter and processor
// - main reset always resets converter and drives processor reset
// - target reset and analyse inputs ignored outside mode 0
// - byte-stream modes translate data/strobe bytes to legacy frames and back
// - legacy receive samples five times per bit period
// - legacy links up to 20 Mbit/s, data/strobe up to 100 Mbit/s
// - legacy byte is start, one, eight bits lsb first, stop
// - acknowledge is start then zero; sender waits for it
module lpcm_top (
    input wire logic i_mclk,
    input wire logic i_reset,
    input wire logic i_mode_select_low,
    input wire logic i_mode_select_high,
    input wire logic i_target_reset_in,
    input wire logic i_analyse_in,
    input wire logic i_processor_booted,
    input wire logic i_legacy_link_zero_rx,
    output logic o_legacy_link_zero_tx,
    input wire logic i_tx_valid,
    input wire logic [7:0] i_tx_data,
    output logic o_tx_ready,
    output logic o_rx_valid,
    output logic [7:0] o_rx_data,
    input wire logic i_rx_ready,
    output logic o_reset_to_processor,
    output logic o_byte_stream,
    output logic o_master_from_pins,
    output logic o_link0_preboot,
    output logic [1:0] o_mode
);
    typedef enum logic [3:0] {
        TX_IDLE = 4'h1,
        TX_SEND = 4'h2,
        TX_WAIT = 4'h4,
        TX_ACK = 4'h8
    } lpcm_tx_t;
    typedef enum logic [2:0] {
        RX_IDLE = 3'h1,
        RX_BITS = 3'h2,
        RX_HOLD = 3'h4
    } lpcm_rx_t;

    logic [1:0] pins_s1_q;
    logic [1:0] pins_s2_q;
    logic [1:0] ctl_s1_q;
    logic [1:0] ctl_s2_q;
    logic [1:0] rx_s_q;
    logic rst_pend_q;
    logic [1:0] mode_q;
    logic latched_q;
    logic int_reset;
    logic [15:0] rout_cnt_q;
    logic [7:0] div_q;
    logic tick;
    lpcm_tx_t tx_st_q;
    lpcm_rx_t rx_st_q;
    logic [10:0] tx_sh_q;
    logic [3:0] tx_bit_q;
    logic [3:0] tx_ph_q;
    logic ack_req_q;
    logic ack_seen_q;
    logic [3:0] rx_bit_q;
    logic [3:0] rx_ph_q;
    logic [8:0] rx_sh_q;
    logic rx_push;
    logic rx_buf_ready;
    logic tx_pop;
    logic tx_buf_valid;
    logic [7:0] tx_buf_data;
    logic link_on;
    logic booted_s1_q;
    logic booted_s2_q;
    logic tx_await_q;
    lpcm_pkg::lpcm_mode_t mode_dec;

    function automatic lpcm_pkg::lpcm_mode_t decode(input logic [1:0] m);
        lpcm_pkg::lpcm_mode_t r;
        r.byte_stream = ~m[0];
        r.master_from_pins = (m == lpcm_pkg::MODE_BYTE_MASTER_PINS);
        r.link0_preboot = m[1];
        return r;
    endfunction

    assign mode_dec = decode(mode_q);

    always_ff @(posedge i_mclk) begin
        pins_s1_q <= {i_mode_select_high, i_mode_select_low};
        pins_s2_q <= pins_s1_q;
        ctl_s1_q <= {i_target_reset_in, i_analyse_in};
        ctl_s2_q <= ctl_s1_q;
        rx_s_q <= {rx_s_q[0], i_legacy_link_zero_rx};
        booted_s1_q <= i_processor_booted;
        booted_s2_q <= booted_s1_q;
    end

    // mode captured on the first edge after reset release; pins assumed stable
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            latched_q <= 1'b0;
            mode_q <= lpcm_pkg::MODE_BYTE_MASTER_PINS;
        end else if (!latched_q) begin
            latched_q <= 1'b1;
            mode_q <= {pins_s2_q[1], pins_s2_q[0]};
        end
    end

    // target reset only counts in mode 0 and only with analyse low
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            rst_pend_q <= 1'b0;
        end else begin
            rst_pend_q <= latched_q && mode_dec.master_from_pins
                && ctl_s2_q[1] && !ctl_s2_q[0];
        end
    end

    assign int_reset = i_reset || rst_pend_q || !latched_q;

    // reset output is stretched so the processor always sees a full pulse
    always_ff @(posedge i_mclk) begin
        if (i_reset || rst_pend_q) begin
            rout_cnt_q <= lpcm_pkg::RESET_OUT_CYCLES;
            o_reset_to_processor <= 1'b1;
        end else if (rout_cnt_q != '0) begin
            rout_cnt_q <= rout_cnt_q - 16'h0001;
            o_reset_to_processor <= 1'b1;
        end else begin
            o_reset_to_processor <= 1'b0;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (int_reset) begin
            o_byte_stream <= 1'b0;
            o_master_from_pins <= 1'b0;
            o_link0_preboot <= 1'b0;
            o_mode <= 2'h0;
        end else begin
            o_byte_stream <= mode_dec.byte_stream;
            o_master_from_pins <= mode_dec.master_from_pins;
            o_link0_preboot <= mode_dec.link0_preboot && !booted_s2_q;
            o_mode <= mode_q;
        end
    end

    // byte path active only in byte-stream modes, and not while link zero is in pre-boot
    assign link_on = mode_dec.byte_stream
        && !(mode_dec.link0_preboot && !booted_s2_q);

    // sample tick at five per bit at the top legacy rate
    always_ff @(posedge i_mclk) begin
        if (int_reset || div_q == 8'(lpcm_pkg::SAMPLE_DIV - 1)) begin
            div_q <= 8'h00;
        end else begin
            div_q <= div_q + 8'h01;
        end
    end
    assign tick = (div_q == 8'(lpcm_pkg::SAMPLE_DIV - 1));

    // held in reset while the byte path is off, so ready reads low there
    lpcm_buf #(.WIDTH(8), .DEPTH(lpcm_pkg::BUF_DEPTH)) u_tx_buf (
        .i_mclk(i_mclk),
        .i_reset(int_reset || !link_on),
        .i_valid(i_tx_valid && link_on),
        .o_ready(o_tx_ready),
        .i_data(i_tx_data),
        .o_valid(tx_buf_valid),
        .i_ready(tx_pop),
        .o_data(tx_buf_data)
    );
    assign tx_pop = tick && (tx_st_q == TX_IDLE) && tx_buf_valid && !ack_req_q && link_on;

    always_ff @(posedge i_mclk) begin
        if (int_reset) begin
            tx_st_q <= TX_IDLE;
            tx_sh_q <= '0;
            tx_bit_q <= '0;
            tx_ph_q <= '0;
            tx_await_q <= 1'b0;
            o_legacy_link_zero_tx <= 1'b0;
        end else if (tick) begin
            unique case (tx_st_q)
                TX_IDLE: begin
                    tx_ph_q <= '0;
                    tx_bit_q <= '0;
                    if (ack_req_q) begin
                        tx_sh_q <= 11'h001;
                        tx_st_q <= TX_ACK;
                    end else if (tx_buf_valid && link_on) begin
                        tx_sh_q <= {1'b0, tx_buf_data, 2'b11};
                        tx_st_q <= TX_SEND;
                    end
                end
                TX_SEND, TX_ACK: begin
                    o_legacy_link_zero_tx <= tx_sh_q[0];
                    if (tx_ph_q == 4'(lpcm_pkg::OVERSAMPLE - 1)) begin
                        tx_ph_q <= '0;
                        tx_sh_q <= {1'b0, tx_sh_q[10:1]};
                        tx_bit_q <= tx_bit_q + 4'h1;
                        if (tx_bit_q == ((tx_st_q == TX_ACK) ? 4'h1
                                : 4'(lpcm_pkg::FRAME_BITS - 1))) begin
                            // an ack sent while awaiting ours must not free the next frame
                            if (tx_st_q == TX_ACK) begin
                                tx_st_q <= tx_await_q ? TX_WAIT : TX_IDLE;
                            end else begin
                                tx_await_q <= 1'b1;
                                tx_st_q <= TX_WAIT;
                            end
                        end
                    end else begin
                        tx_ph_q <= tx_ph_q + 4'h1;
                    end
                end
                TX_WAIT: begin
                    o_legacy_link_zero_tx <= 1'b0;
                    if (ack_seen_q) begin
                        tx_await_q <= 1'b0;
                        tx_st_q <= TX_IDLE;
                    end else if (ack_req_q) begin
                        tx_sh_q <= 11'h001;
                        tx_st_q <= TX_ACK;
                    end
                end
                default: tx_st_q <= TX_IDLE;
            endcase
        end
    end

    // received data and acknowledges; ack withheld until buffer has room
    always_ff @(posedge i_mclk) begin
        if (int_reset) begin
            rx_st_q <= RX_IDLE;
            rx_bit_q <= '0;
            rx_ph_q <= '0;
            rx_sh_q <= '0;
            ack_seen_q <= 1'b0;
            ack_req_q <= 1'b0;
        end else begin
            if (tick && tx_st_q == TX_WAIT && ack_seen_q) begin
                ack_seen_q <= 1'b0;
            end
            // cleared as the ack frame starts; a request raised meanwhile is kept
            if (tick && ack_req_q && (tx_st_q == TX_IDLE
                    || (tx_st_q == TX_WAIT && !ack_seen_q))) begin
                ack_req_q <= 1'b0;
            end
            if (tick) begin
                unique case (rx_st_q)
                    RX_IDLE: begin
                        if (rx_s_q[1] && link_on) begin
                            rx_ph_q <= 4'h0;
                            rx_bit_q <= 4'h0;
                            rx_st_q <= RX_BITS;
                        end
                    end
                    RX_BITS: begin
                        if (rx_ph_q == 4'(lpcm_pkg::OVERSAMPLE - 1)) begin
                            rx_ph_q <= '0;
                        end else begin
                            rx_ph_q <= rx_ph_q + 4'h1;
                        end
                        // mid-bit sample picks the third of five
                        if (rx_ph_q == 4'h2) begin
                            rx_bit_q <= rx_bit_q + 4'h1;
                            if (rx_bit_q == 4'h1 && !rx_s_q[1]) begin
                                ack_seen_q <= 1'b1;
                                rx_st_q <= RX_IDLE;
                            end else if (rx_bit_q >= 4'h2) begin
                                rx_sh_q <= {rx_s_q[1], rx_sh_q[8:1]};
                                if (rx_bit_q == 4'(lpcm_pkg::FRAME_BITS - 1)) begin
                                    rx_st_q <= RX_HOLD;
                                end
                            end
                        end
                    end
                    RX_HOLD: begin
                        if (rx_buf_ready) begin
                            ack_req_q <= 1'b1;
                            rx_st_q <= RX_IDLE;
                        end
                    end
                    default: rx_st_q <= RX_IDLE;
                endcase
            end
        end
    end
    assign rx_push = tick && rx_st_q == RX_HOLD && rx_buf_ready;

    lpcm_buf #(.WIDTH(8), .DEPTH(lpcm_pkg::BUF_DEPTH)) u_rx_buf (
        .i_mclk(i_mclk),
        .i_reset(int_reset),
        .i_valid(rx_push),
        .o_ready(rx_buf_ready),
        .i_data(rx_sh_q[7:0]),
        .o_valid(o_rx_valid),
        .i_ready(i_rx_ready),
        .o_data(o_rx_data)
    );
endmodule

/* lpcm_monitor.sv */
`timescale 1ns/100ps
module lpcm_monitor (
    input wire logic i_mclk,
    input wire logic i_reset,
    input wire logic i_mode_select_low,
    input wire logic i_mode_select_high,
    input wire logic i_target_reset_in,
    input wire logic i_analyse_in,
    input wire logic i_processor_booted,
    input wire logic o_legacy_link_zero_tx,
    input wire logic o_tx_ready,
    input wire logic o_rx_valid,
    input wire logic [7:0] o_rx_data,
    input wire logic i_rx_ready,
    input wire logic o_reset_to_processor,
    input wire logic o_byte_stream,
    input wire logic o_master_from_pins,
    input wire logic o_link0_preboot,
    input wire logic [1:0] o_mode
);
    logic [4:0] rel_q;
    logic ok;
    always_ff @(posedge i_mclk) begin
        if (i_reset) begin
            rel_q <= 5'h00;
        end else if (rel_q != 5'h1f) begin
            rel_q <= rel_q + 5'h01;
        end
    end
    // decoded outputs read zero only while the internal reset is held, not for the whole stretched reset output
    assign ok = rel_q > 5'h03 && !o_reset_to_processor;
    default clocking @(posedge i_mclk); endclocking
    default disable iff i_reset;
    property p_conv; ok |-> o_byte_stream == !o_mode[0]; endproperty
    a_conv: assert property (p_conv) else $error("conversion type wrong");
    property p_master; ok |-> o_master_from_pins == (o_mode == 2'h0); endproperty
    a_master: assert property (p_master) else $error("master source wrong");
    // pre-boot ends three edges after the booted pin: two sync stages and the output flop
    property p_preboot;
        ok |-> o_link0_preboot == (o_mode[1] && !$past(i_processor_booted, 3));
    endproperty
    a_preboot: assert property (p_preboot) else $error("preboot flag wrong");
    property p_latch;
        ok && !$past(ok) |-> o_mode == {i_mode_select_high, i_mode_select_low};
    endproperty
    a_latch: assert property (p_latch) else $error("mode not from pins");
    property p_hold; ok && $past(ok) |-> $stable(o_mode); endproperty
    a_hold: assert property (p_hold) else $error("mode changed");
    property p_rst; $fell(i_reset) |-> o_reset_to_processor [*8]; endproperty
    a_rst: assert property (p_rst) else $error("reset not passed on");
    property p_rst_end;
        rel_q == 5'h1e && !i_target_reset_in |-> !o_reset_to_processor;
    endproperty
    a_rst_end: assert property (p_rst_end) else $error("reset stretch too long");
    property p_tgt;
        o_master_from_pins ##0 (i_target_reset_in && !i_analyse_in) [*3]
            |-> ##[0:4] o_reset_to_processor;
    endproperty
    a_tgt: assert property (p_tgt) else $error("target reset lost");
    property p_ign;
        rel_q == 5'h1f && (i_mode_select_high || i_mode_select_low) |-> !o_reset_to_processor;
    endproperty
    a_ign: assert property (p_ign) else $error("target reset not ignored");
    property p_bit; $rose(o_legacy_link_zero_tx) |-> o_legacy_link_zero_tx [*5]; endproperty
    a_bit: assert property (p_bit) else $error("start bit width");
    property p_stall; o_rx_valid && !i_rx_ready |=> o_rx_valid && $stable(o_rx_data); endproperty
    a_stall: assert property (p_stall) else $error("rx word lost");
    property p_pkt; rel_q == 5'h1f && o_mode[0] |-> !o_tx_ready; endproperty
    a_pkt: assert property (p_pkt) else $error("byte taken in packet mode");
endmodule
bind lpcm_top lpcm_monitor i_mon (.i_mclk(i_mclk), .i_reset(i_reset),
    .i_mode_select_low(i_mode_select_low), .i_mode_select_high(i_mode_select_high),
    .i_target_reset_in(i_target_reset_in), .i_analyse_in(i_analyse_in),
    .i_processor_booted(i_processor_booted),
    .o_legacy_link_zero_tx(o_legacy_link_zero_tx), .o_tx_ready(o_tx_ready),
    .o_rx_valid(o_rx_valid), .o_rx_data(o_rx_data), .i_rx_ready(i_rx_ready),
    .o_reset_to_processor(o_reset_to_processor), .o_byte_stream(o_byte_stream),
    .o_master_from_pins(o_master_from_pins), .o_link0_preboot(o_link0_preboot),
    .o_mode(o_mode));

/* lpcm_node.sv */
`timescale 1ns/100ps
module lpcm_node (
    input wire logic i_line,
    output logic o_line,
    output logic [7:0] o_byte,
    output logic [31:0] o_nbytes,
    output logic [31:0] o_nacks
);
    int ack_wait = 0;
    initial begin
        o_line = 1'b0;
        o_byte = 8'h00;
        o_nbytes = 32'h0;
        o_nacks = 32'h0;
    end
    // a bit lasts 50 ns; the odd start offset keeps us off the clock's phase
    task automatic send(input logic [10:0] b, input int n);
        #3;
        for (int i = 0; i < n; i++) begin
            o_line = b[i];
            #50;
        end
        o_line = 1'b0;
    endtask
    always begin
        @(posedge i_line);
        #75;
        if (i_line === 1'b0) begin
            o_nacks = o_nacks + 1;
        end else begin
            for (int i = 0; i < 8; i++) begin
                #50;
                o_byte[i] = i_line;
            end
            #50;
            if (i_line === 1'b0)
                o_nbytes = o_nbytes + 1;
            #(ack_wait);
            send(11'h001, 2);
        end
    end
endmodule

/* lpcm_tb.sv */
`timescale 1ns/100ps
module tb;
    logic i_mclk = 1'b0;
    logic i_reset = 1'b1;
    logic [1:0] mode = 2'h0;
    logic tr = 1'b0;
    logic an = 1'b0;
    logic booted = 1'b0;
    logic tx_valid = 1'b0;
    logic [7:0] tx_data = 8'h00;
    logic rx_ready = 1'b1;
    logic rx_line, tx_line, tx_ready, rx_valid, rst_out, bs, mp, pb;
    logic [7:0] rx_data, p_byte;
    logic [1:0] dmode;
    logic [31:0] p_nb, p_na;
    int n_fail = 0;
    int n_checks = 0;
    int cyc = 0;
    lpcm_top i_dut (.i_mclk(i_mclk), .i_reset(i_reset), .i_mode_select_low(mode[0]),
        .i_mode_select_high(mode[1]), .i_target_reset_in(tr), .i_analyse_in(an),
        .i_processor_booted(booted), .i_legacy_link_zero_rx(rx_line),
        .o_legacy_link_zero_tx(tx_line), .i_tx_valid(tx_valid), .i_tx_data(tx_data),
        .o_tx_ready(tx_ready), .o_rx_valid(rx_valid), .o_rx_data(rx_data),
        .i_rx_ready(rx_ready), .o_reset_to_processor(rst_out), .o_byte_stream(bs),
        .o_master_from_pins(mp), .o_link0_preboot(pb), .o_mode(dmode));
    lpcm_node i_partner (.i_line(tx_line), .o_line(rx_line), .o_byte(p_byte),
        .o_nbytes(p_nb), .o_nacks(p_na));
    initial forever #5 i_mclk = ~i_mclk;
    always @(posedge i_mclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            conclude;
        end
    end
    task conclude;
        $display("checks %0d failures %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task cycles(input int n);
        repeat (n) @(posedge i_mclk);
    endtask
    task settle;
        @(negedge i_mclk);
    endtask
    // pins move only while reset is held
    task start(input logic [1:0] m);
        @(posedge i_mclk);
        mode <= m;
        i_reset <= 1'b1;
        cycles(16);
        i_reset <= 1'b0;
        cycles(40);
        settle;
    endtask
    task wait_cnt(input logic [31:0] t, input logic ack);
        int k;
        k = 0;
        while ((ack ? p_na : p_nb) !== t && k < 800) begin
            settle;
            k++;
        end
    endtask
    task push(input logic [7:0] d, output logic ok);
        int k;
        @(posedge i_mclk);
        tx_valid <= 1'b1;
        tx_data <= d;
        k = 0;
        settle;
        while (tx_ready !== 1'b1 && k < 30) begin
            settle;
            k++;
        end
        ok = tx_ready === 1'b1;
        @(posedge i_mclk);
        tx_valid <= 1'b0;
    endtask
    task t_modes;
        int m;
        for (int i = 0; i < 4; i++) begin
            m = i ^ (i >> 1);
            start(m[1:0]);
            chk(dmode, m[1:0]);
            chk(bs, !m[0]);
            chk(mp, m == 0);
            chk(pb, m[1]);
            chk(rst_out, 0);
            chk(tx_ready, m == 0);
        end
        @(posedge i_mclk);
        booted <= 1'b1;
        cycles(8);
        settle;
        chk(tx_ready, 1);
        chk(pb, 0);
        $display("test modes done");
    endtask
    task t_target_reset_in;
        start(2'h0);
        @(posedge i_mclk);
        an <= 1'b1;
        tr <= 1'b1;
        cycles(20);
        settle;
        chk(rst_out, 0);
        @(posedge i_mclk);
        an <= 1'b0;
        cycles(6);
        settle;
        chk(rst_out, 1);
        @(posedge i_mclk);
        tr <= 1'b0;
        cycles(40);
        settle;
        chk({rst_out, mp}, 2'h1);
        start(2'h1);
        @(posedge i_mclk);
        tr <= 1'b1;
        cycles(20);
        settle;
        chk(rst_out, 0);
        @(posedge i_mclk);
        tr <= 1'b0;
        $display("test target reset done");
    endtask
    // far side holds its acknowledge back so the buffer has to fill
    task t_tx;
        logic ok;
        int n;
        logic [31:0] nb;
        start(2'h0);
        nb = p_nb;
        i_partner.ack_wait = 3000;
        n = 0;
        ok = 1'b1;
        while (ok && n < 6) begin
            push({n[3:0], ~n[3:0]}, ok);
            if (ok)
                n++;
        end
        chk(n, lpcm_pkg::BUF_DEPTH + 1);
        i_partner.ack_wait = 0;
        for (int k = 0; k < n; k++) begin
            wait_cnt(nb + k + 1, 1'b0);
            chk(p_byte, {k[3:0], ~k[3:0]});
        end
        $display("test transmit done");
    endtask
    task t_rx;
        int n, k, j;
        logic [31:0] na;
        start(2'h0);
        @(posedge i_mclk);
        rx_ready <= 1'b0;
        na = p_na;
        n = 0;
        do begin
            i_partner.send({1'b0, 8'h3c ^ n[7:0], 2'h3}, 11);
            n++;
            wait_cnt(na + n, 1'b1);
        end while (p_na === na + n && n < 5);
        chk(n, lpcm_pkg::BUF_DEPTH + 1);
        @(posedge i_mclk);
        rx_ready <= 1'b1;
        k = 0;
        j = 0;
        while (k < n && j < 300) begin
            settle;
            j++;
            if (rx_valid === 1'b1) begin
                chk(rx_data, 8'h3c ^ k[7:0]);
                k++;
            end
        end
        chk(k, n);
        wait_cnt(na + n, 1'b1);
        chk(p_na, na + n);
        $display("test receive done");
    endtask
    initial begin
        t_modes;
        t_target_reset_in;
        t_tx;
        t_rx;
        conclude;
    end
endmodule
